// [src/fbd_diag_builder.sv]
// Function
// - Response is standard bytes 0 to 5 then device bytes 6 to 15.
// - Send diagnostics on master request and unsolicited on error.
// - Byte 0 carries station status 1 flags; bits 0, 5, 7 zero.
// - Byte 1 carries station status 2 flags; bit 2 one, bits 6, 7 zero.
// - Byte 2 bit 7 flags overflow; other bits zero.
// - Byte 3 master address; bytes 4 and 5 ident high then low.
// - Byte 6 is fixed header: length ten, code zero.
// - Byte 7 carries configuration fault codes 12h to 17h.
// - Byte 7 carries 40h while user diagnostic data are valid and no fault code 12h to 17h is present.
// - Bytes 11 to 15 come from software-writable user data.
// - User block is six bytes; its base is a configuration value.
// - A zero to one change of control bit 0, or of bit 1 with bit 0 clear, sends a diagnostic.
// - Control value 03h is ignored entirely.
// - Control bit 0 marks user data valid; setting it starts a diagnostic.
// - Control bit 1 requests deletion; bits 2 to 7 reserved.
// - User block bytes 1 to 5 map onto response bytes 11 to 15.
`timescale 1ns/100ps
`default_nettype none

module fbd_diag_builder (
   input  wire logic                  clk,
   input  wire logic                  srst,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Protocol engine side
   input  wire fbd_pkg::fbd_station_t station,
   input  wire logic [7:0]            master_addr,
   input  wire logic [7:0]            fault_code,
   input  wire logic                  diag_req,
   output logic                       tx_valid,
   input  wire logic                  tx_ready,
   output logic [7:0]                 tx_data,
   output logic                       tx_last,
   output logic                       tx_unsolicited,
   output logic [15:0]                block_base,
   output logic                       irq
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      fbd_pkg::fbd_state_t st;
      logic [3:0]          idx;
      logic [15:0][7:0]    frame;
      logic [7:0]          tx_data;
      logic                unsol;
      logic [7:0]          ctrl;
      logic [39:0]         payload;
      logic [15:0]         ident;
      logic [15:0]         base;
      logic                user_valid;
      logic                pend;
      logic [7:0]          prev_fault;
      logic [3:0]          sts;
      logic [3:0]          mask;
      logic [31:0]         prdata;
      logic                rdy;
      logic                err;
   } fbd_regs_t;

   fbd_regs_t s;
   fbd_regs_t next_s;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Known fault codes only; anything else reads as no fault
   function automatic logic fbd_fault_ok(input logic [7:0] c);
      fbd_fault_ok = (c >= fbd_pkg::CODE_PAR_LEN) && (c <= fbd_pkg::CODE_CMP);
   endfunction : fbd_fault_ok

   // Address decode
   function automatic logic fbd_mapped(input logic [7:0] a);
      unique case (a)
         fbd_pkg::REG_CTRL, fbd_pkg::REG_PAY_LO, fbd_pkg::REG_PAY_HI,
         fbd_pkg::REG_IDENT, fbd_pkg::REG_BASE, fbd_pkg::REG_IRQ_STAT,
         fbd_pkg::REG_IRQ_MASK, fbd_pkg::REG_STATE: fbd_mapped = 1'b1;
         default:                                   fbd_mapped = 1'b0;
      endcase
   endfunction : fbd_mapped

   // Snapshot of the whole response
   function automatic logic [15:0][7:0] fbd_build(input fbd_pkg::fbd_station_t stn,
                                                 input logic [7:0]  maddr,
                                                 input logic [15:0] id,
                                                 input logic [7:0]  fault,
                                                 input logic        uvalid,
                                                 input logic [39:0] pay);
      logic [15:0][7:0] f;
      f = '0;
      f[0] = {1'b0, stn.wrong_param, 1'b0, stn.unsupported,
              stn.ext_diag, stn.cfg_mismatch, stn.not_ready, 1'b0};
      f[1] = {2'b00, stn.sync_rx, stn.freeze_rx, stn.resp_mon,
              1'b1, stn.static_diag, stn.need_param};
      f[2] = {stn.overflow, 7'h00};
      f[3] = maddr;
      f[4] = id[15:8];
      f[5] = id[7:0];
      f[6] = {fbd_pkg::DEV_CODE, fbd_pkg::DEV_LEN};
      if (fbd_fault_ok(fault)) begin
         f[7] = fault;
      end else if (uvalid) begin
         f[7] = fbd_pkg::CODE_USER;
      end else begin
         f[7] = fbd_pkg::CODE_NONE;
      end
      for (int i = 0; i < fbd_pkg::USER_BYTES; i++) begin
         f[fbd_pkg::USER_FIRST + i] = pay[8*i +: 8];
      end
      fbd_build = f;
   endfunction : fbd_build

   // ---------------------------------------------------------------
   // Bus request view
   // ---------------------------------------------------------------
   fbd_pkg::fbd_apb_req_t req;
   logic                  wr_en;
   logic                  setup;

   assign req   = '{addr: paddr, write: pwrite, wdata: pwdata};
   assign setup = psel && !penable;
   assign wr_en = psel && penable && s.rdy && req.write && !s.err;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      logic [7:0]  v;
      logic [3:0]  set_irq;
      logic [3:0]  clr_irq;
      logic        fault_evt;
      logic        new_evt;
      v         = req.wdata[7:0];
      set_irq   = 4'h0;
      clr_irq   = 4'h0;
      new_evt   = 1'b0;
      fault_evt = 1'b0;
      next_s    = s;

      // APB setup cycle latches read data and error flag
      next_s.rdy = setup;
      next_s.err = setup && !fbd_mapped(req.addr);
      if (setup) begin
         unique case (req.addr)
            fbd_pkg::REG_CTRL:     next_s.prdata = {24'h00_0000, s.ctrl};
            fbd_pkg::REG_PAY_LO:   next_s.prdata = s.payload[31:0];
            fbd_pkg::REG_PAY_HI:   next_s.prdata = {24'h00_0000, s.payload[39:32]};
            fbd_pkg::REG_IDENT:    next_s.prdata = {16'h0000, s.ident};
            fbd_pkg::REG_BASE:     next_s.prdata = {16'h0000, s.base};
            fbd_pkg::REG_IRQ_STAT: next_s.prdata = {28'h000_0000, s.sts};
            fbd_pkg::REG_IRQ_MASK: next_s.prdata = {28'h000_0000, s.mask};
            fbd_pkg::REG_STATE:    next_s.prdata = {16'h0000, s.frame[7], 4'h0,
                                                   s.pend, s.user_valid, s.unsol,
                                                   s.st == fbd_pkg::FBD_SEND};
            default:               next_s.prdata = 32'h0000_0000;
         endcase
      end

      // Register writes
      if (wr_en) begin
         unique case (req.addr)
            fbd_pkg::REG_CTRL: begin
               if (v != fbd_pkg::CTRL_IGNORED) begin
                  next_s.ctrl = v;
                  if (v[fbd_pkg::CTRL_VALID] && !s.ctrl[fbd_pkg::CTRL_VALID]) begin
                     next_s.user_valid = 1'b1;
                     new_evt           = 1'b1;
                     set_irq[fbd_pkg::IRQ_START] = 1'b1;
                  end else if (v[fbd_pkg::CTRL_DELETE] && !v[fbd_pkg::CTRL_VALID] &&
                               !s.ctrl[fbd_pkg::CTRL_DELETE]) begin
                     next_s.user_valid = 1'b0;
                     new_evt           = 1'b1;
                     set_irq[fbd_pkg::IRQ_DEL] = 1'b1;
                  end else if (!v[fbd_pkg::CTRL_VALID]) begin
                     next_s.user_valid = 1'b0;
                  end
               end
            end
            fbd_pkg::REG_PAY_LO:   next_s.payload[31:0]  = req.wdata;
            fbd_pkg::REG_PAY_HI:   next_s.payload[39:32] = v;
            fbd_pkg::REG_IDENT:    next_s.ident = req.wdata[15:0];
            fbd_pkg::REG_BASE:     next_s.base  = req.wdata[15:0];
            fbd_pkg::REG_IRQ_STAT: clr_irq = req.wdata[3:0];
            fbd_pkg::REG_IRQ_MASK: next_s.mask = req.wdata[3:0];
            default: ;
         endcase
      end

      // A newly appearing fault is reported without a request
      next_s.prev_fault = fault_code;
      fault_evt = fbd_fault_ok(fault_code) && (fault_code != s.prev_fault);
      if (fault_evt) begin
         new_evt = 1'b1;
         set_irq[fbd_pkg::IRQ_FAULT] = 1'b1;
      end
      if (new_evt) begin
         next_s.pend = 1'b1;
      end

      // Response transmitter
      unique case (s.st)
         fbd_pkg::FBD_IDLE: begin
            if (diag_req || s.pend) begin
               next_s.frame   = fbd_build(station, master_addr, s.ident,
                                          fault_code, s.user_valid, s.payload);
               next_s.tx_data = next_s.frame[0];
               next_s.idx     = 4'h0;
               next_s.unsol   = !diag_req;
               next_s.pend    = new_evt;
               next_s.st      = fbd_pkg::FBD_SEND;
            end
         end
         fbd_pkg::FBD_SEND: begin
            if (tx_ready) begin
               if (s.idx == fbd_pkg::LAST_IDX) begin
                  next_s.st = fbd_pkg::FBD_IDLE;
                  set_irq[fbd_pkg::IRQ_SENT] = 1'b1;
               end else begin
                  next_s.idx     = s.idx + 4'h1;
                  next_s.tx_data = s.frame[s.idx + 4'h1];
               end
            end
         end
      endcase

      // Sticky status: a set in the clearing cycle wins
      next_s.sts = (s.sts & ~clr_irq) | set_irq;
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         s         <= '0;
         s.st      <= fbd_pkg::FBD_IDLE;
         s.ctrl    <= fbd_pkg::RST_CTRL;
         s.payload <= fbd_pkg::RST_PAYLOAD;
         s.ident   <= fbd_pkg::RST_IDENT;
         s.base    <= fbd_pkg::RST_BASE;
         s.sts     <= fbd_pkg::RST_IRQ;
         s.mask    <= fbd_pkg::RST_IRQ;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata         = s.prdata;
   assign pready         = s.rdy;
   assign pslverr        = s.rdy && s.err;
   assign tx_valid       = (s.st == fbd_pkg::FBD_SEND);
   assign tx_data        = s.tx_data;
   assign tx_last        = tx_valid && (s.idx == fbd_pkg::LAST_IDX);
   assign tx_unsolicited = s.unsol;
   assign block_base     = s.base;
   assign irq            = |(s.sts & s.mask);

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   AST_HEADER: assert property (tx_valid && s.idx == 4'h6 |-> tx_data == 8'h0A)
      else $error("Header byte wrong");

   AST_BYTE0_FIXED: assert property (tx_valid && s.idx == 4'h0 |->
                                     !tx_data[0] && !tx_data[5] && !tx_data[7])
      else $error("Byte 0 fixed bits wrong");

   AST_BYTE1_FIXED: assert property (tx_valid && s.idx == 4'h1 |->
                                     tx_data[2] && !tx_data[6] && !tx_data[7])
      else $error("Byte 1 fixed bits wrong");

   AST_RESERVED: assert property (tx_valid && s.idx >= 4'h8 && s.idx <= 4'hA |->
                                  tx_data == 8'h00)
      else $error("Reserved byte not zero");

   AST_START: assert property (wr_en && req.addr == fbd_pkg::REG_CTRL && pwdata[0] &&
                               !s.ctrl[0] && pwdata[7:0] != 8'h03 |=>
                               s.user_valid && (s.pend || tx_valid))
      else $error("Start did not queue a diagnostic");

   AST_IGNORE: assert property (wr_en && req.addr == fbd_pkg::REG_CTRL &&
                                pwdata[7:0] == 8'h03 |=> $stable(s.ctrl) && $stable(s.user_valid))
      else $error("Ignored control value acted on");

   AST_DELETE: assert property (wr_en && req.addr == fbd_pkg::REG_CTRL && pwdata[7:0] == 8'h02 &&
                                !s.ctrl[1] |=> !s.user_valid && (s.pend || tx_valid))
      else $error("Delete did not clear and resend");

   AST_REQUEST: assert property (!tx_valid && diag_req |=> tx_valid && s.idx == 4'h0 ##0
                                 !s.unsol)
      else $error("Request not answered");

   AST_USER_CODE: assert property (!tx_valid && (diag_req || s.pend) && s.user_valid &&
                                   fault_code == 8'h00 |=> s.frame[7] == 8'h40)
      else $error("User valid code missing");

   AST_IDENT: assert property (!tx_valid && diag_req |=> s.frame[4] == $past(s.ident[15:8]) &&
                               s.frame[5] == $past(s.ident[7:0]))
      else $error("Ident byte order wrong");

endmodule : fbd_diag_builder

`default_nettype wire

// [src/fbd_pkg.sv]
package fbd_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses on APB)
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_PAY_LO    = 8'h04;
   localparam logic [7:0] REG_PAY_HI    = 8'h08;
   localparam logic [7:0] REG_IDENT     = 8'h0C;
   localparam logic [7:0] REG_BASE      = 8'h10;
   localparam logic [7:0] REG_IRQ_STAT  = 8'h14;
   localparam logic [7:0] REG_IRQ_MASK  = 8'h18;
   localparam logic [7:0] REG_STATE     = 8'h1C;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  RST_CTRL     = 8'h00;
   localparam logic [39:0] RST_PAYLOAD  = 40'h00_0000_0000;
   localparam logic [15:0] RST_IDENT    = 16'h0000;   // Arbitrary neutral value
   localparam logic [15:0] RST_BASE     = 16'h0000;
   localparam logic [3:0]  RST_IRQ      = 4'h0;

   // ---------------------------------------------------------------
   // Control byte fields and special values
   // ---------------------------------------------------------------
   localparam int          CTRL_VALID   = 0;
   localparam int          CTRL_DELETE  = 1;
   localparam logic [7:0]  CTRL_IGNORED = 8'h03;

   // ---------------------------------------------------------------
   // Frame layout
   // ---------------------------------------------------------------
   localparam int          FRAME_BYTES  = 16;
   localparam int          USER_FIRST   = 11;
   localparam int          USER_BYTES   = 5;
   localparam int          BLOCK_BYTES  = 6;
   localparam logic [3:0]  LAST_IDX     = 4'hF;
   localparam logic [5:0]  DEV_LEN      = 6'h0A;    // Ten device bytes
   localparam logic [1:0]  DEV_CODE     = 2'h0;
   localparam logic [7:0]  CODE_NONE    = 8'h00;
   localparam logic [7:0]  CODE_PAR_LEN = 8'h12;
   localparam logic [7:0]  CODE_CFG_LEN = 8'h13;
   localparam logic [7:0]  CODE_CFG_ENT = 8'h14;
   localparam logic [7:0]  CODE_BUF     = 8'h15;
   localparam logic [7:0]  CODE_CFG_MIS = 8'h16;
   localparam logic [7:0]  CODE_CMP     = 8'h17;
   localparam logic [7:0]  CODE_USER    = 8'h40;

   // ---------------------------------------------------------------
   // Interrupt bits
   // ---------------------------------------------------------------
   localparam int IRQ_SENT  = 0;
   localparam int IRQ_START = 1;
   localparam int IRQ_DEL   = 2;
   localparam int IRQ_FAULT = 3;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic {FBD_IDLE, FBD_SEND} fbd_state_t;

   typedef struct packed {
      logic not_ready;
      logic cfg_mismatch;
      logic ext_diag;
      logic unsupported;
      logic wrong_param;
      logic need_param;
      logic static_diag;
      logic resp_mon;
      logic freeze_rx;
      logic sync_rx;
      logic overflow;
   } fbd_station_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic        write;
      logic [31:0] wdata;
   } fbd_apb_req_t;

endpackage : fbd_pkg

// [testbench/fbd_dp_master.sv]
`timescale 1ns/100ps
`default_nettype none

module fbd_dp_master (
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire logic          slow,
   input  wire logic          tx_valid,
   input  wire logic [7:0]    tx_data,
   input  wire logic          tx_last,
   input  wire logic          tx_unsolicited,
   output logic               tx_ready,
   output logic [127:0]       frame,
   output logic               frame_unsol,
   output logic [7:0]         n_frames,
   output logic [7:0]         n_bad_last
);
   // ---------------------------------------------------------------
   // Response sink
   // ---------------------------------------------------------------
   logic [127:0] work;
   logic [3:0]   idx;
   logic         unsol_w;

   // Accepts bytes in order, stalls every other cycle when slow
   always_ff @(posedge clk) begin
      if (srst) begin
         tx_ready    <= 1'b0;
         work        <= '0;
         idx         <= 4'h0;
         unsol_w     <= 1'b0;
         frame       <= '0;
         frame_unsol <= 1'b0;
         n_frames    <= 8'h00;
         n_bad_last  <= 8'h00;
      end else begin
         tx_ready <= slow ? ~tx_ready : 1'b1;
         if (tx_valid && tx_ready) begin
            work[8*idx +: 8] <= tx_data;
            idx              <= tx_last ? 4'h0 : idx + 4'h1;
            if (idx == 4'h0) begin
               unsol_w <= tx_unsolicited;
            end
            if (tx_last !== (idx == 4'hF)) begin
               n_bad_last <= n_bad_last + 8'h01;
            end
            if (tx_last) begin
               frame       <= {tx_data, work[119:0]};
               frame_unsol <= (idx == 4'h0) ? tx_unsolicited : unsol_w;
               n_frames    <= n_frames + 8'h01;
            end
         end
      end
   end
endmodule : fbd_dp_master

`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/100ps
`default_nettype none

module testbench;
   // ---------------------------------------------------------------
   // Signals and tables
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] q;
      logic        e;
   } fbd_row_t;
   localparam fbd_row_t ROWS [7] = '{
      '{fbd_pkg::REG_PAY_LO,   32'h4433_2211, 32'h4433_2211, 1'b0},
      '{fbd_pkg::REG_PAY_HI,   32'hAAAA_AA55, 32'h0000_0055, 1'b0},
      '{fbd_pkg::REG_IDENT,    32'h5A5A_1234, 32'h0000_1234, 1'b0},
      '{fbd_pkg::REG_BASE,     32'hFFFF_0120, 32'h0000_0120, 1'b0},
      '{fbd_pkg::REG_IRQ_MASK, 32'hFFFF_FFF0, 32'h0000_0000, 1'b0},
      '{fbd_pkg::REG_STATE,    32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
      '{8'h20,                 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};
   localparam logic [7:0] RADDR [8] = '{fbd_pkg::REG_CTRL, fbd_pkg::REG_PAY_LO, fbd_pkg::REG_PAY_HI,
      fbd_pkg::REG_IDENT, fbd_pkg::REG_BASE, fbd_pkg::REG_IRQ_STAT, fbd_pkg::REG_IRQ_MASK, fbd_pkg::REG_STATE};
   logic                  clk, srst, psel, penable, pwrite, pready, pslverr, diag_req, slow, rd_e;
   logic                  tx_valid, tx_ready, tx_last, tx_unsolicited, irq, frame_unsol;
   logic [7:0]            paddr, master_addr, fault_code, tx_data, n_frames, n_bad_last, nf, c;
   logic [31:0]           pwdata, prdata, rd_q;
   logic [15:0]           block_base;
   logic [127:0]          frame;
   fbd_pkg::fbd_station_t station;
   int                    miscompares, n_checks;

   // Free-running 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   fbd_diag_builder i_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .station(station), .master_addr(master_addr), .fault_code(fault_code), .diag_req(diag_req),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
      .tx_unsolicited(tx_unsolicited), .block_base(block_base), .irq(irq));

   fbd_dp_master i_master (.clk(clk), .srst(srst), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_unsolicited(tx_unsolicited), .tx_ready(tx_ready), .frame(frame),
      .frame_unsol(frame_unsol), .n_frames(n_frames), .n_bad_last(n_bad_last));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One APB transfer, then one idle cycle
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd_q = prdata;
      rd_e = pslverr;
      if (pready !== 1'b1) begin
         miscompares++;
         $display("[FAIL] pready expected 1 seen %b", pready);
         end_sim();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // Expected response; user bytes at the top
   function automatic logic [127:0] mk_frame(input fbd_pkg::fbd_station_t s, input logic [7:0] code);
      logic [127:0] f;
      f = '0;
      f[7:0]    = {1'b0, s.wrong_param, 1'b0, s.unsupported, s.ext_diag, s.cfg_mismatch, s.not_ready, 1'b0};
      f[15:8]   = {2'b00, s.sync_rx, s.freeze_rx, s.resp_mon, 1'b1, s.static_diag, s.need_param};
      f[23:16]  = {s.overflow, 7'h00};
      f[31:24]  = master_addr;
      f[47:32]  = {8'h34, 8'h12};
      f[55:48]  = 8'h0A;
      f[63:56]  = code;
      f[127:88] = 40'h55_4433_2211;
      return f;
   endfunction : mk_frame

   // Waits for frame number n and compares it
   task automatic got_frame(input logic [7:0] n, input logic [127:0] e, input logic full, input logic u);
      int           k;
      logic [127:0] m;
      m = full ? '1 : {40'h00_0000_0000, {88{1'b1}}};
      k = 0;
      while (n_frames !== n && k < 300) begin
         @(posedge clk);
         k++;
      end
      if (n_frames !== n) begin
         miscompares++;
         $display("[FAIL] frame count expected %0d seen %0d", n, n_frames);
         end_sim();
      end
      chk("frame bytes", e & m, frame & m);
      chk("unsolicited", 128'(u), 128'(frame_unsol));
   endtask : got_frame

   task automatic quiet;
      repeat (40) @(posedge clk);
      chk("frame count", 128'(nf), 128'(n_frames));
   endtask : quiet

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      miscompares = 0;
      n_checks    = 0;
      {srst, psel, penable, pwrite, paddr, pwdata, diag_req, slow} = {4'h8, 8'h00, 32'h0000_0000, 2'b00};
      station     = '0;
      master_addr = 8'h2C;
      fault_code  = 8'h00;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk("tx_valid", 128'(1'b0), 128'(tx_valid));
      chk("irq", 128'(1'b0), 128'(irq));
      foreach (RADDR[i]) begin
         apb(RADDR[i], 1'b0, 32'h0000_0000);
         chk("reset value", 128'(32'h0000_0000), 128'(rd_q));
      end
      foreach (ROWS[i]) begin
         apb(ROWS[i].a, 1'b1, ROWS[i].d);
         chk("slave error", 128'(ROWS[i].e), 128'(rd_e));
         apb(ROWS[i].a, 1'b0, 32'h0000_0000);
         chk("read back", 128'(ROWS[i].q), 128'(rd_q));
      end
      chk("block_base", 128'(16'h0120), 128'(block_base));
      // Master requests with two station patterns
      nf = 8'h00;
      for (int i = 0; i < 2; i++) begin
         slow    <= (i == 0);
         station <= (i == 0) ? 11'h7FF : 11'h2AA;
         @(posedge clk);
         diag_req <= 1'b1;
         @(posedge clk);
         diag_req <= 1'b0;
         nf++;
         got_frame(nf, mk_frame(station, fbd_pkg::CODE_NONE), 1'b0, 1'b0);
      end
      // Fault arriving during a frame is sent after it
      slow     <= 1'b1;
      diag_req <= 1'b1;
      @(posedge clk);
      diag_req <= 1'b0;
      repeat (3) @(posedge clk);
      fault_code <= fbd_pkg::CODE_PAR_LEN;
      got_frame(nf + 8'h01, mk_frame(station, fbd_pkg::CODE_NONE), 1'b0, 1'b0);
      got_frame(nf + 8'h02, mk_frame(station, fbd_pkg::CODE_PAR_LEN), 1'b0, 1'b1);
      nf = nf + 8'h02;
      for (c = 8'h13; c <= 8'h17; c++) begin
         fault_code <= c;
         nf++;
         got_frame(nf, mk_frame(station, c), 1'b0, 1'b1);
      end
      fault_code <= 8'h18;
      quiet();
      fault_code <= 8'h00;
      // User diagnostic start and interrupt
      apb(fbd_pkg::REG_IRQ_STAT, 1'b1, 32'h0000_000F);
      apb(fbd_pkg::REG_CTRL, 1'b1, 32'h0000_0001);
      nf++;
      got_frame(nf, mk_frame(station, fbd_pkg::CODE_USER), 1'b1, 1'b1);
      apb(fbd_pkg::REG_STATE, 1'b0, 32'h0000_0000);
      chk("state", 128'(32'h0000_4006), 128'(rd_q));
      apb(fbd_pkg::REG_IRQ_STAT, 1'b0, 32'h0000_0000);
      chk("irq status", 128'(32'h0000_0003), 128'(rd_q));
      chk("irq masked", 128'(1'b0), 128'(irq));
      apb(fbd_pkg::REG_IRQ_MASK, 1'b1, 32'h0000_0002);
      chk("irq", 128'(1'b1), 128'(irq));
      apb(fbd_pkg::REG_IRQ_STAT, 1'b1, 32'h0000_0002);
      chk("irq cleared", 128'(1'b0), 128'(irq));
      // Both bits set is dropped
      apb(fbd_pkg::REG_CTRL, 1'b1, 32'h0000_0003);
      apb(fbd_pkg::REG_CTRL, 1'b0, 32'h0000_0000);
      chk("control", 128'(32'h0000_0001), 128'(rd_q));
      quiet();
      // Delete request
      apb(fbd_pkg::REG_CTRL, 1'b1, 32'h0000_0002);
      nf++;
      got_frame(nf, mk_frame(station, fbd_pkg::CODE_NONE), 1'b0, 1'b1);
      apb(fbd_pkg::REG_IRQ_STAT, 1'b0, 32'h0000_0000);
      chk("irq status", 128'(32'h0000_0005), 128'(rd_q));
      // Clearing the control byte after delete keeps validity clear without a frame
      apb(fbd_pkg::REG_CTRL, 1'b1, 32'h0000_0000);
      quiet();
      apb(fbd_pkg::REG_STATE, 1'b0, 32'h0000_0000);
      chk("state", 128'(32'h0000_0002), 128'(rd_q));
      chk("last flag errors", 128'(8'h00), 128'(n_bad_last));
      // Second reset in mid-run
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      apb(fbd_pkg::REG_CTRL, 1'b0, 32'h0000_0000);
      chk("control after reset", 128'(32'h0000_0000), 128'(rd_q));
      chk("block_base after reset", 128'(16'h0000), 128'(block_base));
      chk("irq after reset", 128'(1'b0), 128'(irq));
      end_sim();
   end
endmodule : testbench

`default_nettype wire
